/* verilog/ffc_pkg.sv */
// fix/float conversion control: shared constants, register map, types
// assumes a 32-bit AXI4-Lite register bus with 8-bit byte addresses
package ffc_pkg;

	// datapath widths
	localparam int MANT_W = 18;
	localparam int EXP_W  = 9;
	localparam int SC_W   = 6;
	localparam int ADDR_W = 8;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_MANT = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_EXT  = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_EXP  = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_STAT = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_SC   = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_OPB  = 8'h18;

	// command bits of the control register
	localparam int CMD_FIX   = 0;
	localparam int CMD_FLOAT = 1;
	localparam int CMD_ADD   = 2;
	localparam int CMD_SUB   = 3;
	localparam int CMD_ROUND = 4;

	// field positions: sign in exponent register, done in status
	localparam int EXP_SIGN_BIT  = 16;
	localparam int STAT_DONE_BIT = 1;

	// conversion constants: 35 decimal and 43 octal
	localparam logic [EXP_W-1:0] FIX_BIAS   = 9'h023;
	localparam logic [EXP_W-1:0] FLOAT_EXP  = 9'h023;
	localparam logic [SC_W-1:0]  NORM_LIMIT = 6'h23;

	// half-rate phase on which the normalize shift happens
	localparam logic [1:0] NORM_SHIFT_PH = 2'h3;

	// reset values
	localparam logic [MANT_W-1:0] RST_MANT = 18'h00000;
	localparam logic [EXP_W-1:0]  RST_EXP  = 9'h000;
	localparam logic [SC_W-1:0]   RST_SC   = 6'h00;

	// bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_FIX,
		ST_NORM
	} ffc_state_e;

	// status register image, busy in bit 0
	typedef struct packed {
		logic half_pulse;
		logic select;
		logic guard;
		logic carry_flag;
		logic fixable;
		logic fix_zero;
		logic done;
		logic busy;
	} ffc_status_s;

endpackage

/* verilog/ffc_conv_ctrl.sv */
// fix/float conversion control with alu carry, guard and reload logic
// assumes one 10 MHz clock, synchronous reset, AXI4-Lite from same domain
//
// Our own choices: the register addresses and the AXI4-Lite register port.

// Contract
// [RULE1] fix loads counter with 35 minus exponent (code loads 0 for exponents above 35)
// [RULE2] each fix step shifts mantissa pair right
// [RULE3] unfixable fraction flags, clears sign and exponent
// [RULE4] fixable flag when magnitude exceeds one
// [RULE5] float preloads exponent with octal 43
// [RULE6] fix-or-float select enables conversion sequence
// [RULE7] alu overflow reloads accumulator via strobe
// [RULE8] carry out of msb sets carry flag
// [RULE9] guard shows rounding is possible
// [RULE10] two half-rate pulses per normalize shift
// [RULE11] normalize limit counter loaded with octal 43
// [RULE12] fix ends and signals done at zero
module ffc_conv_ctrl
	import ffc_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              srst_i,
	input  wire logic              ce_i,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic                   fix_float_select_o,
	output logic                   fix_shift_step_o,
	output logic                   accumulator_reload_strobe_o,
	output logic                   half_rate_shift_pulse_o,
	output logic                   alu_carry_out_flag_o,
	output logic                   guard_o,
	output logic                   done_o
);

	ffc_state_e        state_q;
	logic [MANT_W-1:0] mantissa_accumulator_q;
	logic [MANT_W-1:0] mantissa_extension_register_q;
	logic [MANT_W-1:0] opb_q;
	logic [EXP_W-1:0]  exponent_accumulator_q;
	logic              sign_q;
	logic [SC_W-1:0]   sc_q;
	logic [1:0]        ph_q;
	logic              fix_zero_q, fixable_q, carry_q, guard_q, select_q;
	logic              step_q, reload_q, half_pulse_q, done_q;
	logic [ADDR_W-1:0] aw_addr_q;
	logic [31:0]       w_data_q;
	logic [3:0]        w_strb_q;
	logic              aw_full_q, w_full_q, bvalid_q, rvalid_q;
	logic [1:0]        bresp_q, rresp_q;
	logic [31:0]       rdata_q;

	logic              do_wr, ar_hs;
	logic [ADDR_W-1:0] wa, ra;
	logic [31:0]       rdata_w;
	logic              rmap_w, wmap_w;
	logic [4:0]        cmd_w;
	logic              cmd_conv_w, frac_w, over_w, carry_w, norm_end_w;
	logic [EXP_W-1:0]  fix_diff_w;
	logic [SC_W-1:0]   fix_cnt_w;
	logic [MANT_W:0]   sum_w;
	logic [2*MANT_W-1:0] mant_w;
	ffc_status_s       status_w;
	logic [31:0]       exp_img_w, mg_mant_w, mg_ext_w, mg_opb_w, mg_exp_w;

	// merge write data into an old value by byte strobes
	function automatic logic [31:0] ffc_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = new_v[8*i +: 8];
			end
		end
		return r;
	endfunction

	// bus handshakes, all frozen while the clock enable is low
	assign s_axi_awready = ce_i & ~aw_full_q & ~bvalid_q;
	assign s_axi_wready  = ce_i & ~w_full_q & ~bvalid_q;
	assign s_axi_arready = ce_i & ~rvalid_q;
	assign s_axi_bvalid  = bvalid_q & ce_i;
	assign s_axi_rvalid  = rvalid_q & ce_i;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_rresp   = rresp_q;
	assign s_axi_rdata   = rdata_q;
	assign do_wr = ce_i & aw_full_q & w_full_q & ~bvalid_q;
	assign ar_hs = s_axi_arvalid & s_axi_arready;
	assign wa = {aw_addr_q[ADDR_W-1:2], 2'h0};
	assign ra = {s_axi_araddr[ADDR_W-1:2], 2'h0};
	assign wmap_w = (wa <= OFF_OPB);
	assign rmap_w = (ra <= OFF_OPB);

	// write channel capture and response
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			aw_full_q <= 1'b0;
			w_full_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
			aw_addr_q <= '0;
			w_data_q  <= '0;
			w_strb_q  <= '0;
		end else if (ce_i) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (do_wr) begin
				aw_full_q <= 1'b0;
				w_full_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= wmap_w ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// read data multiplexer
	always_comb begin
		rdata_w = 32'h00000000;
		unique case (ra)
			OFF_MANT: rdata_w[MANT_W-1:0] = mantissa_accumulator_q;
			OFF_EXT:  rdata_w[MANT_W-1:0] = mantissa_extension_register_q;
			OFF_EXP:  begin
				rdata_w[EXP_W-1:0]    = exponent_accumulator_q;
				rdata_w[EXP_SIGN_BIT] = sign_q;
			end
			OFF_STAT: rdata_w[7:0] = status_w;
			OFF_SC:   rdata_w[SC_W-1:0] = sc_q;
			OFF_OPB:  rdata_w[MANT_W-1:0] = opb_q;
			default:  rdata_w = 32'h00000000;
		endcase
	end

	// read channel, data registered one cycle after address
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h00000000;
			rresp_q  <= RESP_OKAY;
		end else if (ce_i) begin
			if (ar_hs) begin
				rvalid_q <= 1'b1;
				rdata_q  <= rdata_w;
				rresp_q  <= rmap_w ? RESP_OKAY : RESP_SLVERR;
			end else if (rvalid_q && s_axi_rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	// command decode and combined conversion select
	assign cmd_w = (do_wr && wa == OFF_CTRL && w_strb_q[0]) ?
		w_data_q[4:0] : 5'h00;
	// [RULE6] fix or float select
	assign cmd_conv_w = cmd_w[CMD_FIX] | cmd_w[CMD_FLOAT];

	// fix arithmetic: shift count and fraction test
	assign frac_w = exponent_accumulator_q[EXP_W-1] |
		(exponent_accumulator_q == RST_EXP);
	assign over_w = ~exponent_accumulator_q[EXP_W-1] &
		(exponent_accumulator_q > FIX_BIAS);
	assign fix_diff_w = FIX_BIAS - exponent_accumulator_q;
	assign fix_cnt_w  = over_w ? RST_SC : fix_diff_w[SC_W-1:0];
	assign mant_w = {mantissa_accumulator_q, mantissa_extension_register_q};

	// alu: add, subtract via complement, round by guard bit
	always_comb begin
		if (cmd_w[CMD_SUB]) begin
			sum_w = {1'b0, mantissa_accumulator_q} + {1'b0, ~opb_q}
				+ (MANT_W+1)'(1);
		end else if (cmd_w[CMD_ROUND]) begin
			sum_w = {1'b0, mantissa_accumulator_q}
				+ (MANT_W+1)'(mantissa_extension_register_q[MANT_W-1]);
		end else begin
			sum_w = {1'b0, mantissa_accumulator_q} + {1'b0, opb_q};
		end
	end
	assign carry_w = sum_w[MANT_W];

	// normalize ends when leading bit set, value zero or limit spent
	assign norm_end_w = mantissa_accumulator_q[MANT_W-1] |
		(mant_w == '0) | (sc_q == RST_SC);

	// conversion sequencer and mantissa/exponent datapath
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			state_q <= ST_IDLE;
			mantissa_accumulator_q        <= RST_MANT;
			mantissa_extension_register_q <= RST_MANT;
			opb_q    <= RST_MANT;
			exponent_accumulator_q <= RST_EXP;
			sign_q   <= 1'b0;
			sc_q     <= RST_SC;
			ph_q     <= 2'h0;
			fix_zero_q <= 1'b0;
			fixable_q  <= 1'b0;
			carry_q  <= 1'b0;
			select_q <= 1'b0;
			step_q   <= 1'b0;
			reload_q <= 1'b0;
			half_pulse_q <= 1'b0;
		end else if (ce_i) begin
			step_q   <= 1'b0;
			reload_q <= 1'b0;
			half_pulse_q <= 1'b0;
			unique case (state_q)
				ST_IDLE: begin
					if (do_wr && wa == OFF_MANT) begin
						mantissa_accumulator_q <= mg_mant_w[MANT_W-1:0];
					end
					if (do_wr && wa == OFF_EXT) begin
						mantissa_extension_register_q <=
							mg_ext_w[MANT_W-1:0];
					end
					if (do_wr && wa == OFF_OPB) begin
						opb_q <= mg_opb_w[MANT_W-1:0];
					end
					if (do_wr && wa == OFF_EXP) begin
						exponent_accumulator_q <= mg_exp_w[EXP_W-1:0];
						sign_q <= mg_exp_w[EXP_SIGN_BIT];
					end
					if (cmd_conv_w && cmd_w[CMD_FIX]) begin
						fix_zero_q <= frac_w;
						fixable_q  <= ~frac_w;
						if (frac_w) begin
							// [RULE3] clear unfixable fraction
							sign_q <= 1'b0;
							exponent_accumulator_q <= RST_EXP;
						end else begin
							// [RULE1] load fix count
							sc_q     <= fix_cnt_w;
							// [RULE4] fixable enters shifting
							select_q <= 1'b1;
							state_q  <= ST_FIX;
						end
					end else if (cmd_conv_w) begin
						// [RULE5] preload float exponent
						exponent_accumulator_q <= FLOAT_EXP;
						// [RULE11] bound normalize shifts
						sc_q     <= NORM_LIMIT;
						ph_q     <= 2'h0;
						select_q <= 1'b1;
						state_q  <= ST_NORM;
					end else if (cmd_w[CMD_ADD] || cmd_w[CMD_SUB] ||
						cmd_w[CMD_ROUND]) begin
						// [RULE8] carry out of msb
						carry_q <= carry_w;
						if (carry_w && !cmd_w[CMD_SUB]) begin
							// [RULE7] overflow reload strobe
							mantissa_accumulator_q <= sum_w[MANT_W:1];
							exponent_accumulator_q <=
								exponent_accumulator_q + EXP_W'(1);
							reload_q <= 1'b1;
						end else begin
							mantissa_accumulator_q <= sum_w[MANT_W-1:0];
						end
					end
				end
				ST_FIX: begin
					if (sc_q == RST_SC) begin
						// [RULE12] terminal count ends fix
						select_q <= 1'b0;
						state_q  <= ST_IDLE;
					end else begin
						// [RULE2] step count, shift pair right
						sc_q   <= sc_q - SC_W'(1);
						{mantissa_accumulator_q,
							mantissa_extension_register_q} <= mant_w >> 1;
						step_q <= 1'b1;
					end
				end
				ST_NORM: begin
					// [RULE10] pulse on phases 0 and 2
					ph_q <= ph_q + 2'h1;
					half_pulse_q <= ~ph_q[0];
					if (ph_q == NORM_SHIFT_PH) begin
						if (norm_end_w) begin
							select_q <= 1'b0;
							state_q  <= ST_IDLE;
						end else begin
							sc_q <= sc_q - SC_W'(1);
							exponent_accumulator_q <=
								exponent_accumulator_q - EXP_W'(1);
							{mantissa_accumulator_q,
								mantissa_extension_register_q} <= mant_w << 1;
						end
					end
				end
			endcase
		end
	end

	// exponent register image for byte-merged writes
	always_comb begin
		exp_img_w = 32'h00000000;
		exp_img_w[EXP_W-1:0]    = exponent_accumulator_q;
		exp_img_w[EXP_SIGN_BIT] = sign_q;
	end

	// write data merged into each data register by byte strobes
	assign mg_mant_w = ffc_merge(32'(mantissa_accumulator_q), w_data_q,
		w_strb_q);
	assign mg_ext_w  = ffc_merge(32'(mantissa_extension_register_q),
		w_data_q, w_strb_q);
	assign mg_opb_w  = ffc_merge(32'(opb_q), w_data_q, w_strb_q);
	assign mg_exp_w  = ffc_merge(exp_img_w, w_data_q, w_strb_q);

	// [RULE9] guard from extension msb
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			guard_q <= 1'b0;
		end else if (ce_i) begin
			guard_q <= mantissa_extension_register_q[MANT_W-1];
		end
	end

	// sticky done, set wins over a software clear
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			done_q <= 1'b0;
		end else if (ce_i) begin
			if (select_q && ((state_q == ST_FIX && sc_q == RST_SC) ||
				(state_q == ST_NORM && ph_q == NORM_SHIFT_PH &&
				norm_end_w))) begin
				done_q <= 1'b1;
			end else if (cmd_conv_w && cmd_w[CMD_FIX] && frac_w) begin
				done_q <= 1'b1;
			end else if (do_wr && wa == OFF_STAT && w_strb_q[0] &&
				w_data_q[STAT_DONE_BIT]) begin
				done_q <= 1'b0;
			end
		end
	end

	// status image and side outputs
	assign status_w = '{half_pulse: half_pulse_q, select: select_q,
		guard: guard_q, carry_flag: carry_q, fixable: fixable_q,
		fix_zero: fix_zero_q, done: done_q,
		busy: (state_q != ST_IDLE)};
	assign fix_float_select_o          = select_q;
	assign fix_shift_step_o            = step_q;
	assign accumulator_reload_strobe_o = reload_q;
	assign half_rate_shift_pulse_o     = half_pulse_q;
	assign alu_carry_out_flag_o        = carry_q;
	assign guard_o                     = guard_q;
	assign done_o                      = done_q;

	// checks on the conversion and alu behaviour
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);

	a_fix_count_load: assert property ( // [RULE1]
		state_q == ST_IDLE && cmd_w[CMD_FIX] && !frac_w
		|=> sc_q == $past(fix_cnt_w) && state_q == ST_FIX)
		else $error("fix count not loaded");
	a_fix_shift_pair: assert property ( // [RULE2]
		ce_i && state_q == ST_FIX && sc_q != RST_SC
		|=> mant_w == ($past(mant_w) >> 1) && fix_shift_step_o)
		else $error("fix step did not shift right");
	a_fix_zero_clear: assert property ( // [RULE3]
		state_q == ST_IDLE && cmd_w[CMD_FIX] && frac_w
		|=> !sign_q && exponent_accumulator_q == RST_EXP && fix_zero_q)
		else $error("fraction not cleared");
	a_fixable_flag: assert property ( // [RULE4]
		state_q == ST_FIX |-> fixable_q && !fix_zero_q)
		else $error("shifting without fixable flag");
	a_float_preload: assert property ( // [RULE5]
		state_q == ST_IDLE && cmd_w[CMD_FLOAT] && !cmd_w[CMD_FIX]
		|=> exponent_accumulator_q == FLOAT_EXP && sc_q == NORM_LIMIT)
		else $error("float preload wrong");
	a_select_busy: assert property ( // [RULE6]
		state_q != ST_IDLE |-> fix_float_select_o)
		else $error("select low during conversion");
	a_reload_strobe: assert property ( // [RULE7]
		state_q == ST_IDLE && cmd_w[CMD_ADD] && carry_w && !cmd_w[CMD_SUB]
		&& !cmd_conv_w |=> accumulator_reload_strobe_o &&
		mantissa_accumulator_q == $past(sum_w[MANT_W:1]))
		else $error("overflow reload missing");
	a_carry_flag: assert property ( // [RULE8]
		state_q == ST_IDLE && !cmd_conv_w && cmd_w[CMD_ROUND]
		|=> alu_carry_out_flag_o == $past(carry_w))
		else $error("carry flag mismatch");
	a_guard_track: assert property ( // [RULE9]
		ce_i ##1 ce_i |-> guard_o == $past(mant_w[MANT_W-1]))
		else $error("guard not tracking");
	a_half_two_pulse: assert property ( // [RULE10]
		ce_i && state_q == ST_NORM && ph_q == NORM_SHIFT_PH &&
		!norm_end_w |-> $past(half_rate_shift_pulse_o, 2) &&
		!$past(half_rate_shift_pulse_o))
		else $error("normalize shift without two pulses");
	a_norm_limit: assert property ( // [RULE11]
		ce_i && state_q == ST_NORM && ph_q == NORM_SHIFT_PH && !norm_end_w
		|=> sc_q == $past(sc_q) - SC_W'(1))
		else $error("normalize limit not counted");
	a_fix_end: assert property ( // [RULE12]
		ce_i && state_q == ST_FIX && sc_q == RST_SC
		|=> state_q == ST_IDLE && done_o)
		else $error("fix did not finish");

	c_fix_run: cover property (state_q == ST_FIX ##1 state_q == ST_IDLE);
	c_fix_frac: cover property (cmd_w[CMD_FIX] && frac_w);
	c_float_norm: cover property (state_q == ST_NORM && fix_shift_step_o
		== 1'b0 ##1 state_q == ST_IDLE);
	c_reload: cover property (accumulator_reload_strobe_o);

endmodule

/* verif/ffc_bus_model.sv */
// far-side register bus master standing in for the instruction sequencer
// assumes the AXI4-Lite slave of ffc_conv_ctrl on the same rising clock
module ffc_bus_model
	import ffc_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              go_i,
	input  wire logic              we_i,
	input  wire logic [ADDR_W-1:0] addr_i,
	input  wire logic [31:0]       data_i,
	output logic                   done_o,
	output logic [31:0]            rdata_o,
	output logic [1:0]             resp_o,
	output logic [ADDR_W-1:0]      awaddr_o,
	output logic                   awvalid_o,
	input  wire logic              awready_i,
	output logic [31:0]            wdata_o,
	output logic                   wvalid_o,
	input  wire logic              wready_i,
	input  wire logic [1:0]        bresp_i,
	input  wire logic              bvalid_i,
	output logic                   bready_o,
	output logic [ADDR_W-1:0]      araddr_o,
	output logic                   arvalid_o,
	input  wire logic              arready_i,
	input  wire logic [31:0]       rdata_i,
	input  wire logic [1:0]        rresp_i,
	input  wire logic              rvalid_i,
	output logic                   rready_o
);
	// idle bus at time zero
	initial begin
		{done_o, awvalid_o, wvalid_o, bready_o, arvalid_o, rready_o} = '0;
		{rdata_o, resp_o, awaddr_o, wdata_o, araddr_o} = '0;
	end

	// one transfer per go; released payload shows the inverse, not stale data
	always @(posedge clk_i) begin
		done_o <= 1'b0;
		if (go_i && we_i) begin
			{awaddr_o, wdata_o} <= {addr_i, data_i};
			{awvalid_o, wvalid_o, bready_o} <= 3'h7;
		end
		if (go_i && !we_i) begin
			araddr_o <= addr_i;
			{arvalid_o, rready_o} <= 2'h3;
		end
		if (awvalid_o && awready_i) begin
			awvalid_o <= 1'b0;
			awaddr_o <= ~awaddr_o;
		end
		if (wvalid_o && wready_i) begin
			wvalid_o <= 1'b0;
			wdata_o <= ~wdata_o;
		end
		if (bvalid_i && bready_o) begin
			{bready_o, done_o, resp_o} <= {2'h1, bresp_i};
		end
		if (arvalid_o && arready_i) begin
			arvalid_o <= 1'b0;
			araddr_o <= ~araddr_o;
		end
		if (rvalid_i && rready_o) begin
			{rready_o, done_o, resp_o, rdata_o} <= {2'h1, rresp_i, rdata_i};
		end
	end
endmodule

/* verif/ffc_conv_ctrl_tb.sv */
// self-checking bench for the fix/float conversion control
// assumes ffc_bus_model as register bus master, 100 ns clock
module ffc_conv_ctrl_tb import ffc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, srst = 1, ce = 1, go = 0, we = 0, done_m;
	logic [ADDR_W-1:0] addr = '0, awaddr, araddr;
	logic [31:0] data = '0, wdata, rdata_s, rdata_m, q;
	logic [1:0] bresp, rresp, resp, r;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic sel, step, strobe, hpulse, carry, guard, done;
	logic sel_seen = 0, adj = 0, hp_prev = 0;
	int steps = 0, pulses = 0, strobes = 0, miscompares = 0, num_checks = 0;

	ffc_conv_ctrl ffc_conv_ctrl_i (.clk_i(clk), .srst_i(srst), .ce_i(ce),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata_s), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .fix_float_select_o(sel),
		.fix_shift_step_o(step), .accumulator_reload_strobe_o(strobe),
		.half_rate_shift_pulse_o(hpulse), .alu_carry_out_flag_o(carry),
		.guard_o(guard), .done_o(done));

	ffc_bus_model ffc_bus_model_i (.clk_i(clk), .go_i(go), .we_i(we),
		.addr_i(addr), .data_i(data), .done_o(done_m), .rdata_o(rdata_m),
		.resp_o(resp), .awaddr_o(awaddr), .awvalid_o(awvalid),
		.awready_i(awready), .wdata_o(wdata), .wvalid_o(wvalid),
		.wready_i(wready), .bresp_i(bresp), .bvalid_i(bvalid),
		.bready_o(bready), .araddr_o(araddr), .arvalid_o(arvalid),
		.arready_i(arready), .rdata_i(rdata_s), .rresp_i(rresp),
		.rvalid_i(rvalid), .rready_o(rready));

	// clock generator
	initial begin
		forever #50 clk = ~clk;
	end

	// tally pulses and levels seen on the control outputs
	always @(posedge clk) begin
		if (ce && step === 1'b1) steps++;
		if (ce && strobe === 1'b1) strobes++;
		if (ce && hpulse === 1'b1) pulses++;
		if (sel === 1'b1) sel_seen = 1'b1;
		if (hpulse === 1'b1 && hp_prev === 1'b1) adj = 1'b1;
		hp_prev = hpulse;
	end

	task automatic check(input logic [31:0] seen, expv, input string m);
		num_checks++;
		if (seen !== expv) begin
			miscompares++;
			$display("ERROR %0t: %s seen %h expected %h", $time, m, seen, expv);
		end
	endtask

	task automatic test_done();
		if (miscompares == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// one bus transfer through the model, bounded wait for its answer
	task automatic bus(input logic w, input logic [ADDR_W-1:0] a,
		input logic [31:0] d);
		int i;
		@(posedge clk);
		{go, we, addr, data} <= {1'b1, w, a, d};
		@(posedge clk);
		go <= 1'b0;
		for (i = 0; i < 40 && done_m !== 1'b1; i++) @(posedge clk);
		check(done_m, 1'b1, "bus answer");
		{q, r} = {rdata_m, resp};
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic wait_done();
		int i;
		for (i = 0; i < 400 && done !== 1'b1; i++) @(posedge clk);
		check(done, 1'b1, "done flag");
	endtask

	// start a command with done cleared and tallies zeroed
	task automatic issue(input logic [31:0] cmd);
		wr(OFF_STAT, 32'h2);
		{steps, pulses, strobes, sel_seen, adj} = '0;
		wr(OFF_CTRL, cmd);
	endtask

	task automatic t_reset_map();
		bus(1'b0, OFF_STAT, 0); check(q, 0, "status after reset");
		bus(1'b0, 8'h1C, 0); check(r, RESP_SLVERR, "unmapped rd resp");
		check(q, 0, "unmapped rd data");
		wr(8'h1C, 32'h5); check(r, RESP_SLVERR, "unmapped wr");
	endtask

	task automatic t_fix(input logic [31:0] e, input int n);
		logic [35:0] pr;
		pr = {18'h3FFFF, 18'h00000} >> n;
		wr(OFF_MANT, 32'h3FFFF); wr(OFF_EXT, 0); wr(OFF_EXP, e);
		issue(32'h1);
		wait_done();
		check(steps, n, "fix steps");
		bus(1'b0, OFF_MANT, 0); check(q, pr[35:18], "fix mant");
		bus(1'b0, OFF_EXT, 0); check(q, pr[17:0], "fix ext");
		bus(1'b0, OFF_SC, 0); check(q, 0, "fix count end");
		bus(1'b0, OFF_STAT, 0); check(q & 32'hF, 32'hA, "fix st");
		check(sel_seen, 1'b1, "fix select");
	endtask

	task automatic t_fraction();
		wr(OFF_EXP, 32'h10000);
		issue(32'h1);
		wait_done();
		bus(1'b0, OFF_EXP, 0); check(q, 0, "fraction exp sign");
		bus(1'b0, OFF_STAT, 0); check(q & 32'hF, 32'h6, "fraction st");
		check(steps, 0, "fraction steps");
	endtask

	task automatic t_busy_refuse();
		wr(OFF_OPB, 32'h11); wr(OFF_EXP, 32'h1);
		issue(32'h1);
		wr(OFF_OPB, 32'h22);
		wait_done();
		bus(1'b0, OFF_OPB, 0); check(q, 32'h11, "write while busy");
	endtask

	// clock enable low in mid-fix freezes count, shifts and select
	task automatic t_ce_freeze();
		int s;
		wr(OFF_MANT, 32'h3FFFF); wr(OFF_EXT, 0); wr(OFF_EXP, 32'h1);
		issue(32'h1);
		@(posedge clk);
		ce <= 1'b0;
		@(posedge clk);
		s = steps;
		repeat (10) @(posedge clk);
		check(steps, s, "frozen steps");
		check(sel, 1'b1, "frozen select");
		ce <= 1'b1;
		wait_done();
		check(steps, 34, "steps after freeze");
		bus(1'b0, OFF_MANT, 0); check(q, 0, "freeze mant");
		bus(1'b0, OFF_EXT, 0); check(q, 32'h3, "freeze ext");
	endtask

	task automatic t_float();
		wr(OFF_MANT, 32'h20000);
		issue(32'h2);
		wait_done();
		bus(1'b0, OFF_EXP, 0); check(q, FLOAT_EXP, "float exp");
		bus(1'b0, OFF_SC, 0); check(q, NORM_LIMIT, "norm limit");
		check(sel_seen, 1'b1, "float select");
		wr(OFF_MANT, 32'h1); wr(OFF_EXT, 32'h0);
		issue(32'h2);
		wait_done();
		bus(1'b0, OFF_MANT, 0); check(q, 32'h20000, "normalized");
		bus(1'b0, OFF_SC, 0); check(q, 32'h12, "norm count");
		check(pulses, 36, "half pulses");
		check(adj, 1'b0, "adjacent pulses");
	endtask

	task automatic t_alu();
		wr(OFF_MANT, 32'h3FFFF); wr(OFF_OPB, 32'h1); wr(OFF_EXP, 32'h3);
		issue(32'h4);
		check(strobes, 1, "add reload");
		check(carry, 1'b1, "add carry");
		check(sel_seen, 1'b0, "alu select");
		bus(1'b0, OFF_MANT, 0); check(q, 32'h20000, "reload mant");
		bus(1'b0, OFF_EXP, 0); check(q, 32'h4, "reload exp");
		wr(OFF_MANT, 32'h5); wr(OFF_OPB, 32'h2);
		issue(32'h8);
		check(strobes, 0, "sub reload");
		check(carry, 1'b1, "sub no borrow");
		wr(OFF_MANT, 32'h1);
		issue(32'h8);
		check(carry, 1'b0, "sub borrow");
		wr(OFF_EXT, 32'h20000);
		repeat (2) @(posedge clk);
		check(guard, 1'b1, "guard set");
		issue(32'h10);
		check(carry, 1'b1, "round carry");
		check(strobes, 1, "round reload");
		bus(1'b0, OFF_MANT, 0); check(q, 32'h20000, "round mant");
		wr(OFF_EXT, 32'h0);
		repeat (2) @(posedge clk);
		check(guard, 1'b0, "guard clear");
	endtask

	// main sequence
	initial begin
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		t_reset_map();
		t_fix(32'h5, 30);
		t_fix(32'h1, 34);
		t_fix(32'h23, 0);
		t_fraction();
		t_busy_refuse();
		t_ce_freeze();
		t_float();
		t_alu();
		test_done();
	end

	// watchdog
	initial begin
		#3000000;
		miscompares++;
		test_done();
	end
endmodule
